// file: common/xfr_defs.svh
`ifndef XFR_DEFS_SVH
`define XFR_DEFS_SVH

// instruction word width
`define XFR_OP_W            10
// documented opcodes of the transfer group
`define XFR_OP_PORT_STRUCT3 10'h22b
`define XFR_OP_WAKE0        10'h21b
`define XFR_OP_WAKE1        10'h214
`define XFR_OP_WAKE2        10'h215
// opcodes with no legible encoding, overridable per core
`define XFR_OP_IRQ1_DFLT    10'h217
`define XFR_OP_SERIAL1_DFLT 10'h202
// destination register indices
`define XFR_IDX_PORT3       0
`define XFR_IDX_IRQ1        1
`define XFR_IDX_SERIAL1     2
`define XFR_IDX_WAKE0       3
`define XFR_IDX_WAKE1       4
`define XFR_IDX_WAKE2       5
`define XFR_NUM_DEST        6
// reset value of every control register
`define XFR_CTRL_RST        4'h0
// instruction shape shared by the whole group
`define XFR_WORDS           1
`define XFR_CYCLES          1

`endif

// file: common/xfr_pkg.sv
package xfr_pkg;

   // accumulator and control register nibble
   typedef logic [3:0] xfr_nib_t;

   // one-hot destination select; bit 0 means nothing is written
   typedef enum logic [6:0] {
      XFR_DEST_NONE    = 7'h01,
      XFR_DEST_PORT3   = 7'h02,
      XFR_DEST_IRQ1    = 7'h04,
      XFR_DEST_SERIAL1 = 7'h08,
      XFR_DEST_WAKE0   = 7'h10,
      XFR_DEST_WAKE1   = 7'h20,
      XFR_DEST_WAKE2   = 7'h40
   } xfr_dest_e;

endpackage

// file: common/xfr_wr_if.sv
`timescale 1ns/1ps
// write strobes and data from the decoder to the control registers
interface xfr_wr_if;
   logic [5:0]       wrEn;    // one-hot register write enable
   xfr_pkg::xfr_nib_t wrData; // accumulator value to store
   modport source (output wrEn, output wrData);
   modport sink   (input wrEn, input wrData);
endinterface

// file: rtl/xfr_ctrl_reg.sv
`timescale 1ns/1ps
`include "xfr_defs.svh"
// one 4-bit control register loaded from the accumulator
module xfr_ctrl_reg #(
   parameter int unsigned IDX = 0
) (
   input  wire logic        mclk,
   input  wire logic        reset,
   xfr_wr_if.sink           wr,
   output xfr_pkg::xfr_nib_t value
);
   import xfr_pkg::*;

   xfr_nib_t valueD; // next register content

   // load only when this index is strobed, else hold
   always_comb begin
      valueD = value;
      if (wr.wrEn[IDX]) begin
         valueD = wr.wrData;
      end
   end

   // register; synchronous reset clears the configuration
   always_ff @(posedge mclk) begin
      if (reset) begin
         value <= `XFR_CTRL_RST;
      end else begin
         value <= valueD;
      end
   end
endmodule

// file: rtl/xfr_acc_xfer.sv
`timescale 1ns/1ps
`include "xfr_defs.svh"
// Behaviour
// - opcode 22b copies accumulator to port ctrl3
// - dedicated opcode loads interrupt ctrl 1
// - dedicated opcode loads serial ctrl 1
// - opcode 21b loads key wakeup ctrl 0
// - opcode 214 loads key wakeup ctrl 1
// - opcode 215 loads key wakeup ctrl 2
module xfr_acc_xfer #(
   // opcodes whose encoding differs between core variants
   parameter logic [9:0] OP_IRQ1    = `XFR_OP_IRQ1_DFLT,
   parameter logic [9:0] OP_SERIAL1 = `XFR_OP_SERIAL1_DFLT
) (
   input  wire logic         mclk,
   input  wire logic         reset,
   // instruction executing in this cycle
   input  wire logic         instrValid,
   input  wire logic [9:0]   instrCode,
   // current accumulator contents
   input  xfr_pkg::xfr_nib_t accIn,
   // the six control registers
   output xfr_pkg::xfr_nib_t portOutputStructureCtrl3,
   output xfr_pkg::xfr_nib_t interruptCtrl1,
   output xfr_pkg::xfr_nib_t serialIfCtrl1,
   output xfr_pkg::xfr_nib_t keyWakeupCtrl0,
   output xfr_pkg::xfr_nib_t keyWakeupCtrl1,
   output xfr_pkg::xfr_nib_t keyWakeupCtrl2,
   // execution status toward the core
   output logic              xferDone,
   output logic [5:0]        xferDest,
   output logic              foreignOp,
   output logic              skipNext,
   output logic              carryFlagWrite,
   output logic              accWrite
);
   import xfr_pkg::*;

   // decoded destination of the current word
   xfr_dest_e dest;

   // carrier of write strobes toward the register slices
   xfr_wr_if wr ();

   // outputs of the register slices
   xfr_nib_t regValue [`XFR_NUM_DEST];

   // status state
   logic       xferDone_q;       // a group transfer finished
   logic       xferDone_d;
   logic [5:0] xferDest_q;       // which register it wrote
   logic [5:0] xferDest_d;
   logic       foreignOp_q;      // valid word outside this group
   logic       foreignOp_d;
   logic       skipNext_q;       // skip request, never raised here
   logic       skipNext_d;
   logic       carryWrite_q;     // carry update, never raised here
   logic       carryWrite_d;
   logic       accWrite_q;       // accumulator update, never raised
   logic       accWrite_d;

   // decode: compare the executing word against each group opcode.
   // an if chain, not a unique case, because the two overridable
   // opcodes could be set equal to a fixed one by mistake and a
   // fixed priority keeps the result defined in that case
   always_comb begin
      dest = XFR_DEST_NONE;
      if (instrValid) begin
         if (instrCode == `XFR_OP_PORT_STRUCT3) begin
            dest = XFR_DEST_PORT3;
         end else if (instrCode == OP_IRQ1) begin
            dest = XFR_DEST_IRQ1;
         end else if (instrCode == OP_SERIAL1) begin
            dest = XFR_DEST_SERIAL1;
         end else if (instrCode == `XFR_OP_WAKE0) begin
            dest = XFR_DEST_WAKE0;
         end else if (instrCode == `XFR_OP_WAKE1) begin
            dest = XFR_DEST_WAKE1;
         end else if (instrCode == `XFR_OP_WAKE2) begin
            dest = XFR_DEST_WAKE2;
         end else begin
            dest = XFR_DEST_NONE; // not ours, leave to other decoders
         end
      end
   end

   // strobes: accumulator is only read, never written back
   always_comb begin
      wr.wrEn   = dest[6:1];
      wr.wrData = accIn;
   end

   // one register slice per destination; each stores at the edge
   // that closes the single execution cycle
   genvar gi;
   generate
      for (gi = 0; gi < `XFR_NUM_DEST; gi++) begin : g_reg
         xfr_ctrl_reg #(
            .IDX   (gi)
         ) u_reg (
            .mclk  (mclk),
            .reset (reset),
            .wr    (wr),
            .value (regValue[gi])
         );
      end
   endgenerate

   // register slice values onto named outputs; these are flop outputs
   assign portOutputStructureCtrl3 = regValue[`XFR_IDX_PORT3];
   assign interruptCtrl1           = regValue[`XFR_IDX_IRQ1];
   assign serialIfCtrl1            = regValue[`XFR_IDX_SERIAL1];
   assign keyWakeupCtrl0           = regValue[`XFR_IDX_WAKE0];
   assign keyWakeupCtrl1           = regValue[`XFR_IDX_WAKE1];
   assign keyWakeupCtrl2           = regValue[`XFR_IDX_WAKE2];

   // status next values: a one-cycle report of what just executed
   always_comb begin
      xferDone_d   = (dest != XFR_DEST_NONE);
      xferDest_d   = dest[6:1];
      foreignOp_d  = instrValid && (dest == XFR_DEST_NONE);
      // every word of the group is single-cycle with no skip
      skipNext_d   = 1'b0;
      // carry flag is left untouched by the whole group
      carryWrite_d = 1'b0;
      // the source accumulator keeps its value
      accWrite_d   = 1'b0;
   end

   // status registers; reset drops every report
   always_ff @(posedge mclk) begin
      if (reset) begin
         xferDone_q   <= 1'b0;
         xferDest_q   <= 6'h00;
         foreignOp_q  <= 1'b0;
         skipNext_q   <= 1'b0;
         carryWrite_q <= 1'b0;
         accWrite_q   <= 1'b0;
      end else begin
         xferDone_q   <= xferDone_d;
         xferDest_q   <= xferDest_d;
         foreignOp_q  <= foreignOp_d;
         skipNext_q   <= skipNext_d;
         carryWrite_q <= carryWrite_d;
         accWrite_q   <= accWrite_d;
      end
   end

   // status outputs, each straight from its flop
   assign xferDone       = xferDone_q;
   assign xferDest       = xferDest_q;
   assign foreignOp      = foreignOp_q;
   assign skipNext       = skipNext_q;
   assign carryFlagWrite = carryWrite_q;
   assign accWrite       = accWrite_q;
endmodule

// file: tb/xfr_acc_xfer_checker.sv
`timescale 1ns/1ps
`include "xfr_defs.svh"
// watches the transfer block from its top ports only
module xfr_acc_xfer_checker #(
   parameter logic [9:0] OP_IRQ1    = `XFR_OP_IRQ1_DFLT,
   parameter logic [9:0] OP_SERIAL1 = `XFR_OP_SERIAL1_DFLT
) (
   input wire logic          mclk,
   input wire logic          reset,
   input wire logic          instrValid,
   input wire logic [9:0]    instrCode,
   input xfr_pkg::xfr_nib_t  accIn,
   input xfr_pkg::xfr_nib_t  portOutputStructureCtrl3,
   input xfr_pkg::xfr_nib_t  interruptCtrl1,
   input xfr_pkg::xfr_nib_t  serialIfCtrl1,
   input xfr_pkg::xfr_nib_t  keyWakeupCtrl0,
   input xfr_pkg::xfr_nib_t  keyWakeupCtrl1,
   input xfr_pkg::xfr_nib_t  keyWakeupCtrl2,
   input wire logic          xferDone,
   input wire logic [5:0]    xferDest,
   input wire logic          foreignOp,
   input wire logic          skipNext,
   input wire logic          carryFlagWrite,
   input wire logic          accWrite
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // a group opcode lands the accumulator in its register one edge later
   property p_ld(op, r, d);
      instrValid && instrCode == op |=>
         r == $past(accIn) && xferDest == d && xferDone;
   endproperty
   a_port3_load: assert property (p_ld(10'h22b,
      portOutputStructureCtrl3, 6'h01)) else $error("port3 load wrong");
   a_irq1_load: assert property (p_ld(OP_IRQ1,
      interruptCtrl1, 6'h02)) else $error("irq1 load wrong");
   a_serial1_load: assert property (p_ld(OP_SERIAL1,
      serialIfCtrl1, 6'h04)) else $error("serial1 load wrong");
   a_wake0_load: assert property (p_ld(10'h21b,
      keyWakeupCtrl0, 6'h08)) else $error("wake0 load wrong");
   a_wake1_load: assert property (p_ld(10'h214,
      keyWakeupCtrl1, 6'h10)) else $error("wake1 load wrong");
   a_wake2_load: assert property (p_ld(10'h215,
      keyWakeupCtrl2, 6'h20)) else $error("wake2 load wrong");
   // skip, carry and accumulator are never touched by this group
   a_no_side_effect: assert property (
      !skipNext && !carryFlagWrite && !accWrite) else $error("side effect");
   // with no instruction, nothing moves
   a_idle_holds: assert property (!instrValid |=> !xferDone &&
      $stable({portOutputStructureCtrl3, interruptCtrl1, serialIfCtrl1,
      keyWakeupCtrl0, keyWakeupCtrl1, keyWakeupCtrl2}))
      else $error("idle cycle changed state");
   c_done: cover property (xferDone);
   c_foreign: cover property (foreignOp);
   c_back_to_back: cover property (xferDone [*2]);
endmodule
bind xfr_acc_xfer xfr_acc_xfer_checker #(.OP_IRQ1(OP_IRQ1),
   .OP_SERIAL1(OP_SERIAL1)) chk (.mclk, .reset, .instrValid, .instrCode,
   .accIn, .portOutputStructureCtrl3, .interruptCtrl1, .serialIfCtrl1,
   .keyWakeupCtrl0, .keyWakeupCtrl1, .keyWakeupCtrl2, .xferDone, .xferDest,
   .foreignOp, .skipNext, .carryFlagWrite, .accWrite);

// file: tb/test_xfr_acc_xfer.sv
`timescale 1ns/1ps
`include "xfr_defs.svh"
module test_xfr_acc_xfer;
   import xfr_pkg::*;
   logic        mclk = 0, reset = 1, instrValid = 0;
   logic [9:0]  instrCode = 10'h000;
   xfr_nib_t    accIn = 4'h0;
   xfr_nib_t    regs [6];        // design registers, in dest bit order
   logic        xferDone, foreignOp, skipNext, carryFlagWrite, accWrite;
   logic [5:0]  xferDest;
   logic [9:0]  ops [6] = '{`XFR_OP_PORT_STRUCT3, `XFR_OP_IRQ1_DFLT,
      `XFR_OP_SERIAL1_DFLT, `XFR_OP_WAKE0, `XFR_OP_WAKE1, `XFR_OP_WAKE2};
   xfr_nib_t    expReg [6] = '{default: 4'h0}; // model registers
   logic [5:0]  expDest = 6'h00; // model pulse, one-hot
   logic        expFor = 1'b0;
   logic [31:0] seed = 32'h1a20c673;
   int          mismatches = 0, checked = 0, cycles = 0, i;
   always #25 mclk = ~mclk;
   xfr_acc_xfer DUT (.mclk(mclk), .reset(reset), .instrValid(instrValid),
      .instrCode(instrCode), .accIn(accIn),
      .portOutputStructureCtrl3(regs[0]), .interruptCtrl1(regs[1]),
      .serialIfCtrl1(regs[2]), .keyWakeupCtrl0(regs[3]),
      .keyWakeupCtrl1(regs[4]), .keyWakeupCtrl2(regs[5]),
      .xferDone(xferDone), .xferDest(xferDest), .foreignOp(foreignOp),
      .skipNext(skipNext), .carryFlagWrite(carryFlagWrite),
      .accWrite(accWrite));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(string n, logic [5:0] seen, logic [5:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // one cycle: check last cycle's effect, drive the next, advance model
   task automatic cyc(logic r, logic v, logic [9:0] c, xfr_nib_t a);
      @(posedge mclk);
      reset <= r;
      instrValid <= v;
      instrCode <= c;
      accIn <= a;
      #1;
      foreach (regs[k]) chk("register", 6'(regs[k]), 6'(expReg[k]));
      chk("dest", xferDest, expDest);
      chk("done", 6'(xferDone), 6'(expDest != 6'h00));
      chk("foreign", 6'(foreignOp), 6'(expFor));
      chk("sideeffects", 6'({skipNext, carryFlagWrite, accWrite}), 6'h00);
      expDest = 6'h00;
      expFor = 1'b0;
      if (r) expReg = '{default: 4'h0};
      else if (v) begin
         expFor = 1'b1;
         foreach (ops[k]) if (c === ops[k]) begin
            expReg[k] = a;
            expDest = 6'(1 << k);
            expFor = 1'b0;
         end
      end
   endtask
   // cut a hang short
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      repeat (5) cyc(1'b1, 1'b0, 10'h000, 4'h0);
      // every opcode back to back, then the same register twice
      foreach (ops[k]) cyc(1'b0, 1'b1, ops[k], 4'(k + 9));
      cyc(1'b0, 1'b1, ops[3], 4'hf);
      cyc(1'b0, 1'b1, ops[3], 4'h6);
      cyc(1'b0, 1'b0, ops[0], 4'h1);
      $display("test directed done");
      for (i = 0; i < 600; i++) begin
         logic [31:0] r;
         r = rnd();
         cyc(i == 300, r[4] | r[5], r[3] ? ops[r[2:0] % 6] : r[9:0],
            r[19:16]);
      end
      $display("test random with mid reset done");
      cyc(1'b0, 1'b0, 10'h000, 4'h0);
      conclude();
   end
endmodule
